//--- dtc_checker.sv
// Concurrent checks on the bus and interrupt ports of the timer block.
`timescale 1ns/1ps
`include "dtc_map.vh"
module dtc_checker (
    input wire        aclk,
    input wire        aresetn,
    input wire        s_axi_awready,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        vector_ack_0,
    input wire        vector_ack_1,
    input wire        irq_0,
    input wire        irq_1
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped before bready");
    write_answer_a: assert property (s_axi_awready && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing after address and data");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read data missing after address");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed before rready");
    read_width_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    resp_code_a: assert property (s_axi_bvalid |->
        (s_axi_bresp == `DTC_RESP_OKAY || s_axi_bresp == `DTC_RESP_SLVERR))
        else $error("illegal write response code");
    ready_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("address ready longer than one cycle");
    ack_clear0_a: assert property (vector_ack_0 && irq_0 |-> ##2 !irq_0)
        else $error("timer 0 request not cleared by vectoring");
    ack_clear1_a: assert property (vector_ack_1 && irq_1 |-> ##2 !irq_1)
        else $error("timer 1 request not cleared by vectoring");
    cover property ($rose(irq_0));
    cover property ($rose(irq_1));
    cover property (s_axi_arvalid && s_axi_arready);
endmodule

bind dtc_top dtc_checker i_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .vector_ack_0(vector_ack_0), .vector_ack_1(vector_ack_1), .irq_0(irq_0), .irq_1(irq_1));

//--- dtc_map.vh
// Register map, field positions and timing constants of the dual timer/counter.
`ifndef DTC_MAP_VH
`define DTC_MAP_VH
`define DTC_OFF_CONTROL    8'h00
`define DTC_OFF_MODE       8'h04
`define DTC_OFF_T0_LOW     8'h08
`define DTC_OFF_T1_LOW     8'h0c
`define DTC_OFF_T0_HIGH    8'h10
`define DTC_OFF_T1_HIGH    8'h14
`define DTC_OFF_IRQ_ENABLE 8'h18
`define DTC_OFF_IRQ_ACK    8'h1c
`define DTC_CTL_RUN_0      4
`define DTC_CTL_FLAG_0     5
`define DTC_CTL_RUN_1      6
`define DTC_CTL_FLAG_1     7
`define DTC_MOD_T0_LSB     0
`define DTC_MOD_T1_LSB     4
`define DTC_FLD_MODE_LSB   0
`define DTC_FLD_SOURCE     2
`define DTC_FLD_GATING     3
`define DTC_IEN_T0         1
`define DTC_IEN_T1         3
`define DTC_IEN_GLOBAL     7
`define DTC_MODE_13BIT     2'h0
`define DTC_MODE_16BIT     2'h1
`define DTC_MODE_RELOAD    2'h2
`define DTC_MODE_SPLIT     2'h3
`define DTC_PRESCALE_MASK  8'h1f
`define DTC_PRESCALE_TOP   8'h1f
`define DTC_DIV_LAST       3'h5
`define DTC_BYTE_ONES      8'hff
`define DTC_RESP_OKAY      2'h0
`define DTC_RESP_SLVERR    2'h2
`endif

//--- dtc_pin_model.sv
// Model of the external count and gate pins that feed the timer block.
`timescale 1ns/1ps
module dtc_pin_model #(
    parameter HOLD = 12
) (
    input  wire  aclk,
    output logic count_pin_0,
    output logic count_pin_1,
    output logic gate_pin_0,
    output logic gate_pin_1
);
    initial begin
        count_pin_0 = 0;
        count_pin_1 = 0;
        gate_pin_0 = 0;
        gate_pin_1 = 0;
    end
    task automatic level(input int ch, input logic v);
        if (ch == 0) count_pin_0 <= v;
        else count_pin_1 <= v;
        repeat (HOLD) @(posedge aclk);
    endtask
    task automatic pulses(input int ch, input int n);
        repeat (n) begin
            level(ch, 1'b1);
            level(ch, 1'b0);
        end
    endtask
    task automatic set_gate(input int ch, input logic v);
        if (ch == 0) gate_pin_0 <= v;
        else gate_pin_1 <= v;
    endtask
endmodule

//--- dtc_pin_sync.v
// Three-stage synchroniser for a pin, with agreement of the last two stages.
`timescale 1ns/1ps
module dtc_pin_sync (
    input  wire aclk,
    input  wire aresetn,
    input  wire pin,
    output reg  level
);
    reg s1;
    reg s2;
    reg s3;
    always @(posedge aclk) begin
        if (!aresetn) begin
            s1    <= 1'b0;
            s2    <= 1'b0;
            s3    <= 1'b0;
            level <= 1'b0;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                level <= s3;
            end
        end
    end
endmodule

//--- dtc_top.v
// Dual 16-bit timer/counter with four modes, reached over AXI4-Lite.
// Contract
// R1 - 16-bit chaining, high overflow sets flag
// R2 - Count only while run set; no clear
// R3 - Counts readable always; preset when stopped
// R4 - Software stops timer before mode changes
// R5 - Source select: divided clock or pin
// R6 - Timer counts once per six clocks
// R7 - Pin sampled per cycle, falling edge counts
// R8 - Pin levels held one peripheral cycle
// R9 - Timer 0 uses low mode bits
// R10 - Timer 1 uses high mode bits
// R11 - Gating adds gate pin to run
// R12 - Rollover sets overflow flag, requests interrupt
// R13 - Mode 0: five-bit prescaler into high
// R14 - Mode 1: full 16-bit count
// R15 - Mode 2: low byte reloads from high
// R16 - Mode 3 splits timer 0 bytes
// R17 - Timer 1 mode 3 halts, holds count
// R18 - Timer 1 without interrupt during split
// R19 - Flag cleared when interrupt is vectored
// R20 - Interrupt needs own and global enable
// R21 - Two-bit field decodes modes 0..3
// R22 - Gating: count while gate pin high
// R23 - Gate pin sampled per peripheral cycle
//
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "dtc_map.vh"
module dtc_top (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        count_pin_0,
    input  wire        count_pin_1,
    input  wire        gate_pin_0,
    input  wire        gate_pin_1,
    input  wire        vector_ack_0,
    input  wire        vector_ack_1,
    output reg         irq_0,
    output reg         irq_1
);
    ////////////////////////////////////////////////////////////////////////////
    // Registers and pin sampling.
    reg  [7:0] timer_control_reg;
    reg  [7:0] timer_mode_reg;
    reg  [7:0] irq_enable_reg;
    reg  [7:0] count_low_byte_0;
    reg  [7:0] count_high_byte_0;
    reg  [7:0] count_low_byte_1;
    reg  [7:0] count_high_byte_1;
    reg  [2:0] div_cnt;
    reg        count_prev_0;
    reg        count_prev_1;
    reg        count_now_0;
    reg        count_now_1;
    reg        gate_smp_0;
    reg        gate_smp_1;
    wire       cnt_lvl_0;
    wire       cnt_lvl_1;
    wire       gate_lvl_0;
    wire       gate_lvl_1;

    dtc_pin_sync u_sync_c0 (.aclk(aclk), .aresetn(aresetn), .pin(count_pin_0), .level(cnt_lvl_0));
    dtc_pin_sync u_sync_c1 (.aclk(aclk), .aresetn(aresetn), .pin(count_pin_1), .level(cnt_lvl_1));
    dtc_pin_sync u_sync_g0 (.aclk(aclk), .aresetn(aresetn), .pin(gate_pin_0), .level(gate_lvl_0));
    dtc_pin_sync u_sync_g1 (.aclk(aclk), .aresetn(aresetn), .pin(gate_pin_1), .level(gate_lvl_1));

    // One peripheral cycle is six clock periods; the tick closes each one.
    wire tick = (div_cnt == `DTC_DIV_LAST); // R6

    always @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt      <= 3'h0;
            count_prev_0 <= 1'b0;
            count_prev_1 <= 1'b0;
            count_now_0  <= 1'b0;
            count_now_1  <= 1'b0;
            gate_smp_0   <= 1'b0;
            gate_smp_1   <= 1'b0;
        end else begin
            div_cnt <= tick ? 3'h0 : div_cnt + 3'h1; // R6
            if (tick) begin
                count_prev_0 <= count_now_0; // R7
                count_prev_1 <= count_now_1; // R7
                count_now_0  <= cnt_lvl_0; // R7
                count_now_1  <= cnt_lvl_1; // R7
                gate_smp_0   <= gate_lvl_0; // R23
                gate_smp_1   <= gate_lvl_1; // R23
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Field decode and count enables.
    wire [3:0] fld0 = timer_mode_reg[`DTC_MOD_T0_LSB +: 4]; // R9
    wire [3:0] fld1 = timer_mode_reg[`DTC_MOD_T1_LSB +: 4]; // R10
    wire [1:0] mode_0 = fld0[`DTC_FLD_MODE_LSB +: 2]; // R21
    wire [1:0] mode_1 = fld1[`DTC_FLD_MODE_LSB +: 2]; // R21
    wire run_bit_0 = timer_control_reg[`DTC_CTL_RUN_0]; // R9
    wire run_bit_1 = timer_control_reg[`DTC_CTL_RUN_1]; // R10
    // Falling edge between two successive samples, or a timer tick.
    wire fall_0 = count_prev_0 & ~count_now_0; // R7
    wire fall_1 = count_prev_1 & ~count_now_1; // R7
    wire src_0 = fld0[`DTC_FLD_SOURCE] ? (tick & fall_0) : tick; // R5
    wire src_1 = fld1[`DTC_FLD_SOURCE] ? (tick & fall_1) : tick; // R5
    wire en_0 = run_bit_0 & (~fld0[`DTC_FLD_GATING] | gate_smp_0); // R2 R11 R22
    wire en_1 = run_bit_1 & (~fld1[`DTC_FLD_GATING] | gate_smp_1); // R2 R11 R22
    wire split = (mode_0 == `DTC_MODE_SPLIT); // R16
    wire inc_0 = src_0 & en_0;
    // In split mode timer 1 loses its run bit; it runs unless in mode 3.
    wire inc_1 = tick & (split | en_1) & (mode_1 != `DTC_MODE_SPLIT) &
                 (fld1[`DTC_FLD_SOURCE] ? fall_1 : 1'b1); // R17 R18
    wire inc_h0 = tick & run_bit_1; // R16

    ////////////////////////////////////////////////////////////////////////////
    // Next count for one timer in modes 0 to 2.
    function [16:0] next_count;
        input [1:0] mode;
        input [7:0] lo;
        input [7:0] hi;
        reg   [7:0] pre;
        begin
            pre = lo & `DTC_PRESCALE_MASK;
            next_count = {1'b0, hi, lo};
            case (mode)
                `DTC_MODE_13BIT: begin
                    if (pre == `DTC_PRESCALE_TOP) begin
                        next_count = {(hi == `DTC_BYTE_ONES), hi + 8'h01,
                                      lo & ~`DTC_PRESCALE_MASK}; // R13
                    end else begin
                        next_count = {1'b0, hi, lo + 8'h01}; // R13
                    end
                end
                `DTC_MODE_16BIT: begin
                    next_count = {1'b0, hi, lo} + 17'h00001; // R1 R14
                end
                `DTC_MODE_RELOAD: begin
                    if (lo == `DTC_BYTE_ONES) begin
                        next_count = {1'b1, hi, hi}; // R15
                    end else begin
                        next_count = {1'b0, hi, lo + 8'h01}; // R15
                    end
                end
                default: begin
                    next_count = {1'b0, hi, lo};
                end
            endcase
        end
    endfunction

    wire [16:0] nc0 = next_count(mode_0, count_low_byte_0, count_high_byte_0);
    wire [16:0] nc1 = next_count(mode_1, count_low_byte_1, count_high_byte_1);
    wire        ovf_l0 = split ? (inc_0 & (count_low_byte_0 == `DTC_BYTE_ONES))
                               : (inc_0 & nc0[16]); // R12 R16
    wire        ovf_h0 = split & inc_h0 & (count_high_byte_0 == `DTC_BYTE_ONES); // R16
    wire        ovf_t1 = inc_1 & nc1[16] & ~split; // R18
    wire        set_flag_0 = ovf_l0; // R12
    wire        set_flag_1 = ovf_h0 | ovf_t1; // R12 R16

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave.
    reg        aw_held;
    reg        w_held;
    reg  [7:0] aw_addr;
    reg [31:0] w_data;
    reg  [3:0] w_strb;
    wire       do_write = aw_held & w_held & ~s_axi_bvalid;
    wire       wr_lane = w_strb[0];
    wire       wr_ctl  = do_write & wr_lane & (aw_addr == `DTC_OFF_CONTROL);
    wire       wr_mod  = do_write & wr_lane & (aw_addr == `DTC_OFF_MODE);
    wire       wr_l0   = do_write & wr_lane & (aw_addr == `DTC_OFF_T0_LOW);
    wire       wr_l1   = do_write & wr_lane & (aw_addr == `DTC_OFF_T1_LOW);
    wire       wr_h0   = do_write & wr_lane & (aw_addr == `DTC_OFF_T0_HIGH);
    wire       wr_h1   = do_write & wr_lane & (aw_addr == `DTC_OFF_T1_HIGH);
    wire       wr_ien  = do_write & wr_lane & (aw_addr == `DTC_OFF_IRQ_ENABLE);
    wire       wr_ack  = do_write & wr_lane & (aw_addr == `DTC_OFF_IRQ_ACK);
    wire       hit_w = (aw_addr == `DTC_OFF_CONTROL) || (aw_addr == `DTC_OFF_MODE) ||
                       (aw_addr == `DTC_OFF_T0_LOW) || (aw_addr == `DTC_OFF_T1_LOW) ||
                       (aw_addr == `DTC_OFF_T0_HIGH) || (aw_addr == `DTC_OFF_T1_HIGH) ||
                       (aw_addr == `DTC_OFF_IRQ_ENABLE) || (aw_addr == `DTC_OFF_IRQ_ACK);
    // Vectoring clears a flag; a set in the same cycle wins.
    wire clr_0 = vector_ack_0 | (wr_ack & w_data[`DTC_CTL_FLAG_0]); // R19
    wire clr_1 = vector_ack_1 | (wr_ack & w_data[`DTC_CTL_FLAG_1]); // R19

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h00000000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `DTC_RESP_OKAY;
        end else begin
            s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready  <= ~w_held & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid & s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= hit_w ? `DTC_RESP_OKAY : `DTC_RESP_SLVERR;
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `DTC_RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `DTC_RESP_OKAY;
                if (s_axi_araddr == `DTC_OFF_CONTROL) begin
                    s_axi_rdata <= {24'h000000, timer_control_reg};
                end else if (s_axi_araddr == `DTC_OFF_MODE) begin
                    s_axi_rdata <= {24'h000000, timer_mode_reg};
                end else if (s_axi_araddr == `DTC_OFF_T0_LOW) begin
                    s_axi_rdata <= {24'h000000, count_low_byte_0}; // R3
                end else if (s_axi_araddr == `DTC_OFF_T1_LOW) begin
                    s_axi_rdata <= {24'h000000, count_low_byte_1}; // R3
                end else if (s_axi_araddr == `DTC_OFF_T0_HIGH) begin
                    s_axi_rdata <= {24'h000000, count_high_byte_0}; // R3
                end else if (s_axi_araddr == `DTC_OFF_T1_HIGH) begin
                    s_axi_rdata <= {24'h000000, count_high_byte_1}; // R3
                end else if (s_axi_araddr == `DTC_OFF_IRQ_ENABLE) begin
                    s_axi_rdata <= {24'h000000, irq_enable_reg};
                end else if (s_axi_araddr == `DTC_OFF_IRQ_ACK) begin
                    s_axi_rdata <= 32'h00000000;
                end else begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `DTC_RESP_SLVERR;
                end
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control, mode and count registers.
    always @(posedge aclk) begin
        if (!aresetn) begin
            timer_control_reg <= 8'h00;
            timer_mode_reg    <= 8'h00;
            irq_enable_reg    <= 8'h00;
            count_low_byte_0  <= 8'h00;
            count_high_byte_0 <= 8'h00;
            count_low_byte_1  <= 8'h00;
            count_high_byte_1 <= 8'h00;
            irq_0             <= 1'b0;
            irq_1             <= 1'b0;
        end else begin
            if (wr_mod) begin
                timer_mode_reg <= w_data[7:0]; // R4
            end
            if (wr_ien) begin
                irq_enable_reg <= w_data[7:0];
            end
            if (wr_ctl) begin
                timer_control_reg <= w_data[7:0];
            end else begin
                if (clr_0) begin
                    timer_control_reg[`DTC_CTL_FLAG_0] <= 1'b0; // R19
                end
                if (clr_1) begin
                    timer_control_reg[`DTC_CTL_FLAG_1] <= 1'b0; // R19
                end
            end
            if (set_flag_0) begin
                timer_control_reg[`DTC_CTL_FLAG_0] <= 1'b1; // R12
            end
            if (set_flag_1) begin
                timer_control_reg[`DTC_CTL_FLAG_1] <= 1'b1; // R12
            end
            // Timer 0: split keeps the bytes apart, otherwise one counter.
            if (wr_l0) begin
                count_low_byte_0 <= w_data[7:0]; // R3
            end else if (inc_0) begin
                count_low_byte_0 <= split ? count_low_byte_0 + 8'h01 : nc0[7:0]; // R16
            end
            if (wr_h0) begin
                count_high_byte_0 <= w_data[7:0]; // R3 R15
            end else if (split ? inc_h0 : inc_0) begin
                count_high_byte_0 <= split ? count_high_byte_0 + 8'h01 : nc0[15:8]; // R16
            end
            if (wr_l1) begin
                count_low_byte_1 <= w_data[7:0]; // R3
            end else if (inc_1) begin
                count_low_byte_1 <= nc1[7:0];
            end
            if (wr_h1) begin
                count_high_byte_1 <= w_data[7:0]; // R3
            end else if (inc_1) begin
                count_high_byte_1 <= nc1[15:8];
            end
            irq_0 <= timer_control_reg[`DTC_CTL_FLAG_0] & irq_enable_reg[`DTC_IEN_T0] &
                     irq_enable_reg[`DTC_IEN_GLOBAL]; // R20
            irq_1 <= timer_control_reg[`DTC_CTL_FLAG_1] & irq_enable_reg[`DTC_IEN_T1] &
                     irq_enable_reg[`DTC_IEN_GLOBAL]; // R20
        end
    end
endmodule

//--- test_dual_timer_counter.sv
// Self-checking testbench of the dual timer/counter over AXI4-Lite.
`timescale 1ns/1ps
`include "dtc_map.vh"
module test_dual_timer_counter;
    logic        aclk = 0, aresetn = 0, ack_0 = 0, ack_1 = 0;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 0, q, q2;
    logic [1:0]  last_resp;
    wire         awready, wready, bvalid, arready, rvalid, irq_0, irq_1, c0, c1, g0, g1;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    int          fail_count = 0, checks = 0, cyc = 0, span;
    always #12.5 aclk = ~aclk;
    always @(posedge aclk) cyc <= cyc + 1;
    dtc_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .count_pin_0(c0),
        .count_pin_1(c1), .gate_pin_0(g0), .gate_pin_1(g1), .vector_ack_0(ack_0),
        .vector_ack_1(ack_1), .irq_0(irq_0), .irq_1(irq_1));
    dtc_pin_model i_pins (.aclk(aclk), .count_pin_0(c0), .count_pin_1(c1), .gate_pin_0(g0),
        .gate_pin_1(g1));
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk_rng(input string name, input logic [31:0] lo, input logic [31:0] hi,
                           input logic [31:0] got);
        checks++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            fail_count++;
            $display("ERROR %s expected %h to %h seen %h", name, lo, hi, got);
        end
    endtask
    task automatic give_verdict;
        if (fail_count == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic hang;
        fail_count++;
        $display("ERROR wait expected answer seen none");
        give_verdict();
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid && n < 100);
        last_resp = bresp;
        bready <= 0;
        if (n >= 100) hang();
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        int n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 0;
        end while (!rvalid && n < 100);
        d = rdata;
        last_resp = rresp;
        rready <= 0;
        if (n >= 100) hang();
    endtask
    // Runs for a fixed idle time and records the cycles between start and stop.
    task automatic run_for(input logic [31:0] on, input logic [31:0] off);
        int t0;
        wr(`DTC_OFF_CONTROL, on);
        t0 = cyc;
        repeat (60) @(posedge aclk);
        wr(`DTC_OFF_CONTROL, off);
        span = cyc - t0;
    endtask
    initial begin
        repeat (100000) @(posedge aclk);
        hang();
    end
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        for (int a = 0; a <= 32; a += 4) begin
            rd(a[7:0], q);
            chk("reset read", 32'h0, q);
        end
        chk("unmapped resp", `DTC_RESP_SLVERR, last_resp);
        wr(8'h20, 32'hff);
        chk("unmapped write resp", `DTC_RESP_SLVERR, last_resp);
        wr(`DTC_OFF_MODE, 32'h01);
        chk("write resp", `DTC_RESP_OKAY, last_resp);
        wr(`DTC_OFF_T0_LOW, 32'hfe);
        wr(`DTC_OFF_T0_HIGH, 32'h12);
        run_for(32'h10, 32'h00);
        rd(`DTC_OFF_T0_LOW, q);
        rd(`DTC_OFF_T0_HIGH, q2);
        chk_rng("t0 count", span / 6, span / 6 + 1, {q2[7:0], q[7:0]} - 32'h12fe);
        wr(`DTC_OFF_MODE, 32'h00);
        wr(`DTC_OFF_T1_LOW, 32'hfe);
        wr(`DTC_OFF_T1_HIGH, 32'h12);
        run_for(32'h40, 32'h00);
        rd(`DTC_OFF_T1_LOW, q);
        rd(`DTC_OFF_T1_HIGH, q2);
        chk_rng("t1 count", span / 6, span / 6 + 1, {q2[7:0], q[4:0]} - 32'h25e);
        chk("t1 low top", 32'h7, q[7:5]);
        wr(`DTC_OFF_MODE, 32'h02);
        wr(`DTC_OFF_T0_HIGH, 32'hfc);
        wr(`DTC_OFF_T0_LOW, 32'hfc);
        wr(`DTC_OFF_IRQ_ENABLE, 32'h02);
        wr(`DTC_OFF_CONTROL, 32'h10);
        repeat (60) @(posedge aclk);
        rd(`DTC_OFF_CONTROL, q);
        chk("flag0 set", 32'h30, q);
        chk("irq0 no global", 32'h0, irq_0);
        wr(`DTC_OFF_CONTROL, 32'h20);
        rd(`DTC_OFF_T0_LOW, q);
        chk_rng("t0 reload low", 32'hfc, 32'hff, q);
        rd(`DTC_OFF_T0_HIGH, q);
        chk("t0 reload high", 32'hfc, q);
        wr(`DTC_OFF_IRQ_ENABLE, 32'h82);
        repeat (2) @(posedge aclk);
        chk("irq0 on", 32'h1, irq_0);
        ack_0 <= 1;
        @(posedge aclk);
        ack_0 <= 0;
        repeat (2) @(posedge aclk);
        chk("irq0 vectored", 32'h0, irq_0);
        wr(`DTC_OFF_MODE, 32'hd5);
        wr(`DTC_OFF_T1_LOW, 32'h00);
        wr(`DTC_OFF_T0_LOW, 32'h00);
        wr(`DTC_OFF_CONTROL, 32'h50);
        i_pins.pulses(1, 3);
        i_pins.set_gate(1, 1'b1);
        repeat (20) @(posedge aclk);
        i_pins.pulses(1, 5);
        i_pins.pulses(0, 2);
        repeat (30) @(posedge aclk);
        wr(`DTC_OFF_CONTROL, 32'h00);
        rd(`DTC_OFF_T1_LOW, q);
        chk("t1 gated pins", 32'h5, q);
        rd(`DTC_OFF_T0_LOW, q);
        chk("t0 pins", 32'h2, q);
        wr(`DTC_OFF_MODE, 32'h33);
        wr(`DTC_OFF_T0_HIGH, 32'hfe);
        wr(`DTC_OFF_T1_LOW, 32'h55);
        wr(`DTC_OFF_IRQ_ENABLE, 32'h88);
        wr(`DTC_OFF_CONTROL, 32'h40);
        repeat (60) @(posedge aclk);
        rd(`DTC_OFF_CONTROL, q);
        chk("split flag1", 32'hc0, q);
        chk("irq1 split", 32'h1, irq_1);
        wr(`DTC_OFF_CONTROL, 32'h80);
        rd(`DTC_OFF_T0_LOW, q);
        chk("split t0 low", 32'h2, q);
        rd(`DTC_OFF_T1_LOW, q);
        chk("t1 held", 32'h55, q);
        ack_1 <= 1;
        @(posedge aclk);
        ack_1 <= 0;
        repeat (2) @(posedge aclk);
        chk("irq1 vectored", 32'h0, irq_1);
        give_verdict();
    end
endmodule
